// file: itc_pkg.sv
package itc_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS  = 100;
    localparam int unsigned TICK_PERIOD_NS = 1000000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

    // ****************************************
    // Count layout and reset values
    // ****************************************
    localparam int unsigned       COUNT_W     = 16;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_W-1:0] SET_ZERO    = 16'h0000;
    localparam logic [COUNT_W:0]   COUNT_STEP  = 17'h00001;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic {
        ST_IDLE,
        ST_TIMING
    } itc_state_t;

    typedef struct packed {
        itc_state_t         state;
        logic [COUNT_W-1:0] count;
        logic               start_prev;
        logic               out;
        logic               up;
    } itc_core_t;

endpackage

// file: itc_tick_if.sv
`timescale 1ns/1ns
interface itc_tick_if;
    logic restart;
    logic tick;

    modport timer (
        output restart,
        input  tick
    );

    modport divider (
        input  restart,
        output tick
    );
endinterface

// file: itc_tick_div.sv
`timescale 1ns/1ns
module itc_tick_div
    import itc_pkg::*;
#(
    parameter int unsigned CYCLES = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic  clk,
    input  wire logic  rst_n,
    // Time base towards the timer
    itc_tick_if.divider tb
);

    localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);
    localparam logic [W-1:0] ONE  = W'(1);

    generate
        if (CYCLES < 1) begin : g_bad
            $error("itc_tick_div: CYCLES must be at least 1");
        end
    endgenerate

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         tick;
    } itc_div_state_t;

    itc_div_state_t r;
    itc_div_state_t next_r;

    // A restart realigns the phase so the first tick comes a full period on.
    always_comb begin
        next_r = r;
        next_r.tick = 1'b0;
        if (tb.restart) begin
            next_r.cnt = '0;
        end else if (r.cnt == LAST) begin
            next_r.cnt  = '0;
            next_r.tick = 1'b1;
        end else begin
            next_r.cnt = r.cnt + ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tb.tick = r.tick;

endmodule

// file: itc_timer.sv
// Summary of operation
// - A start edge during timing is accepted and restarts the interval.
// - The control output is on while start is on, unless reset is on.
// - When elapsed time reaches the set value the timer clears and stops.
// - With a set value of zero the output only follows start, no timing.
// - Power-up clears the timer and the elapsed count.
`timescale 1ns/1ns
module itc_timer
    import itc_pkg::*;
#(
    parameter int unsigned TICK_COUNT = TICK_CYCLES
) (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               resetn,
    // External controls
    input  wire logic               start_in,
    input  wire logic               gate_in,
    input  wire logic               reset_in,
    input  wire logic [COUNT_W-1:0] set_value,
    // Results
    output logic                    control_out,
    output logic                    timing_active,
    output logic                    time_up,
    output logic [COUNT_W-1:0]      elapsed
);

    generate
        if (TICK_COUNT < 1) begin : g_bad
            $error("itc_timer: TICK_COUNT must be at least 1");
        end
    endgenerate

    // ****************************************
    // Reset release
    // ****************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ****************************************
    // Time base
    // ****************************************
    itc_tick_if tb ();

    itc_tick_div #(
        .CYCLES (TICK_COUNT)
    ) u_div (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .tb    (tb.divider)
    );

    // ****************************************
    // Timing core
    // ****************************************
    itc_core_t r;
    itc_core_t next_r;
    logic      restart;
    logic      reach;
    logic      start_rise;

    // True when the set value asks for plain start-following output.
    function automatic logic set_is_zero(input logic [COUNT_W-1:0] v);
        return v == SET_ZERO;
    endfunction

    always_comb begin
        next_r     = r;
        restart    = 1'b0;
        reach      = 1'b0;
        start_rise = start_in && !r.start_prev;
        next_r.start_prev = start_in;
        next_r.out = start_in && !reset_in;
        next_r.up  = 1'b0;
        if (reset_in) begin
            next_r.state = ST_IDLE;
            next_r.count = COUNT_RESET;
            restart      = 1'b1;
        end else if (start_rise) begin
            next_r.count = COUNT_RESET;
            restart      = 1'b1;
            if (set_is_zero(set_value)) begin
                next_r.state = ST_IDLE;
            end else begin
                next_r.state = ST_TIMING;
            end
        end else begin
            case (r.state)
                ST_TIMING: begin
                    if (set_is_zero(set_value)) begin
                        next_r.state = ST_IDLE;
                        next_r.count = COUNT_RESET;
                    end else if (tb.tick && !gate_in) begin
                        if (({1'b0, r.count} + COUNT_STEP) >=
                            {1'b0, set_value}) begin
                            reach        = 1'b1;
                            next_r.state = ST_IDLE;
                            next_r.count = COUNT_RESET;
                            next_r.up    = 1'b1;
                        end else begin
                            next_r.count = r.count
                                + COUNT_STEP[COUNT_W-1:0];
                        end
                    end
                end
                ST_IDLE: begin
                    next_r.count = COUNT_RESET;
                end
                default: begin
                    next_r.state = ST_IDLE;
                    next_r.count = COUNT_RESET;
                end
            endcase
        end
    end

    // Power-up always lands in idle with a cleared count.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign tb.restart    = restart;
    assign control_out   = r.out;
    assign timing_active = (r.state == ST_TIMING);
    assign time_up       = r.up;
    assign elapsed       = r.count;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_reach;
        reach;
    endsequence

    sequence s_cleared;
        time_up && elapsed == COUNT_RESET && !timing_active;
    endsequence

    sequence s_run_from_zero;
        timing_active && elapsed == COUNT_RESET;
    endsequence

    sequence s_held;
        timing_active && elapsed == $past(elapsed);
    endsequence

    AST_RETRIGGER: assert property (
        (timing_active && start_rise && !reset_in && set_value != SET_ZERO)
        |=> (timing_active && elapsed == COUNT_RESET))
        else $error("start edge during timing did not restart");

    AST_OUT_FOLLOWS: assert property (
        (start_in && !reset_in) [*2] |-> control_out)
        else $error("control output off while start held");

    AST_OUT_OFF: assert property (
        (!start_in || reset_in) |=> !control_out)
        else $error("control output on without start");

    AST_TIME_UP: assert property (
        s_reach |=> s_cleared)
        else $error("timer did not clear at set value");

    AST_ZERO_SET: assert property (
        (set_value == SET_ZERO) [*2] |-> !timing_active)
        else $error("timing runs with zero set value");

    AST_POWER_UP: assert property (
        ($past(rst_n) == 1'b0)
        |-> (elapsed == COUNT_RESET && !timing_active && !control_out))
        else $error("timer not clear after power-up");

    AST_RESET_IN: assert property (
        reset_in |=> (!control_out && !timing_active
                      && elapsed == COUNT_RESET))
        else $error("reset input did not clear timer");

    AST_COUNT_STEP: assert property (
        (timing_active && !start_rise && !reset_in && !reach
         && set_value != SET_ZERO && tb.tick && !gate_in)
        |=> (elapsed == $past(elapsed) + COUNT_STEP[COUNT_W-1:0]))
        else $error("elapsed count did not step on tick");

    AST_START_RUN: assert property (
        (start_rise && !reset_in && !set_is_zero(set_value))
        |=> s_run_from_zero)
        else $error("start edge did not launch an interval");

    AST_UP_PULSE: assert property (
        time_up |=> !time_up)
        else $error("time-up pulse lasted more than one cycle");

    AST_UP_IDLE: assert property (
        time_up |-> !timing_active)
        else $error("interval still running at time up");

    AST_IDLE_CLEAR: assert property (
        !timing_active |-> elapsed == COUNT_RESET)
        else $error("elapsed count kept while idle");

    AST_ZERO_NO_UP: assert property (
        set_is_zero(set_value) |=> !time_up)
        else $error("time up raised with zero set value");

    AST_GATE_HOLD: assert property (
        (timing_active && gate_in && !start_rise && !reset_in
         && !set_is_zero(set_value))
        |=> s_held)
        else $error("elapsed count moved while gated");

endmodule

// file: itc_src.sv
`timescale 1ns/1ns
module itc_src
    import itc_pkg::*;
(
    // Commands from the bench
    input  wire logic               cmd_start,
    input  wire logic               cmd_gate,
    input  wire logic               cmd_reset,
    input  wire logic [COUNT_W-1:0] cmd_set,
    // Switch lines towards the timer
    output logic                    start_in,
    output logic                    gate_in,
    output logic                    reset_in,
    output logic [COUNT_W-1:0]      set_value
);
    // Switches are plain levels that the bench moves at falling edges.
    assign start_in  = cmd_start;
    assign gate_in   = cmd_gate;
    assign reset_in  = cmd_reset;
    assign set_value = cmd_set;
endmodule

// file: tb.sv
`timescale 1ns/1ns
module tb;
    import itc_pkg::*;
    logic               ref_clk = 1'b0;
    logic               resetn = 1'b0;
    logic               s = 1'b0;
    logic               g = 1'b0;
    logic               r = 1'b0;
    logic [COUNT_W-1:0] sv = 16'h0000;
    logic               start_in, gate_in, reset_in;
    logic               control_out, timing_active, time_up;
    logic [COUNT_W-1:0] set_value, elapsed;
    int                 errors = 0;
    int                 tests_run = 0;
    int                 cyc = 0;
    localparam int      TK = 4;
    // Reference model state of the timing core.
    int                 m_age = 0;
    logic               m_prev = 1'b0;
    logic               m_act = 1'b0;
    logic               m_up = 1'b0;
    logic               m_out = 1'b0;
    logic [COUNT_W-1:0] m_cnt = 16'h0000;

    itc_src u_src (.cmd_start(s), .cmd_gate(g), .cmd_reset(r),
        .cmd_set(sv), .start_in(start_in), .gate_in(gate_in),
        .reset_in(reset_in), .set_value(set_value));

    itc_timer #(.TICK_COUNT(TK)) u_dut (.ref_clk(ref_clk),
        .resetn(resetn), .start_in(start_in), .gate_in(gate_in),
        .reset_in(reset_in), .set_value(set_value),
        .control_out(control_out), .timing_active(timing_active),
        .time_up(time_up), .elapsed(elapsed));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            report_and_stop();
        end
    end

    task automatic chk1(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [COUNT_W-1:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Edges from a start edge until the n-th tick has been counted.
    function automatic int run_edges(input int n);
        return TK * n + 1;
    endfunction

    // Advances the model by one clock edge with the inputs it samples.
    task automatic model_edge(input logic st, gt, rs,
                              input logic [COUNT_W-1:0] v);
        logic rise;
        logic tick;
        rise = st && !m_prev;
        m_age = m_age + 1;
        tick = (m_age > 1) && (((m_age - 1) % TK) == 0);
        m_prev = st;
        m_out = st && !rs;
        m_up = 1'b0;
        if (rs || rise) begin
            m_age = 0;
            m_cnt = 16'h0000;
            m_act = !rs && (v != 16'h0000);
        end else if (m_act && (v == 16'h0000)) begin
            m_act = 1'b0;
            m_cnt = 16'h0000;
        end else if (m_act && tick && !gt) begin
            if ((int'(m_cnt) + 1) >= int'(v)) begin
                m_act = 1'b0;
                m_cnt = 16'h0000;
                m_up = 1'b1;
            end else begin
                m_cnt = m_cnt + 16'h0001;
            end
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Makes a fresh start edge with set value v, ends after the edge.
    task automatic fire(input logic [COUNT_W-1:0] v);
        s = 1'b0;
        sv = v;
        step(1);
        s = 1'b1;
        step(1);
    endtask

    initial begin
        void'($urandom(39));
        step(5);
        resetn = 1'b1;
        step(1);
        chk1(control_out, 1'b0);
        step(2);
        chk1(control_out, 1'b0);
        chk16(elapsed, 16'h0000);
        fire(16'h0002);
        chk1(timing_active, 1'b1);
        chk16(elapsed, 16'h0000);
        chk1(control_out, 1'b1);
        step(run_edges(1));
        chk16(elapsed, 16'h0001);
        chk1(time_up, 1'b0);
        step(run_edges(2) - run_edges(1));
        chk1(time_up, 1'b1);
        chk1(timing_active, 1'b0);
        chk16(elapsed, 16'h0000);
        step(1);
        chk1(control_out, 1'b1);
        chk1(time_up, 1'b0);
        chk1(timing_active, 1'b0);
        fire(16'h0003);
        step(run_edges(1));
        chk16(elapsed, 16'h0001);
        fire(16'h0003);
        chk1(timing_active, 1'b1);
        chk16(elapsed, 16'h0000);
        step(run_edges(2));
        chk16(elapsed, 16'h0002);
        chk1(timing_active, 1'b1);
        r = 1'b1;
        step(1);
        chk1(control_out, 1'b0);
        chk1(timing_active, 1'b0);
        chk16(elapsed, 16'h0000);
        r = 1'b0;
        step(1);
        chk1(control_out, 1'b1);
        chk1(timing_active, 1'b0);
        fire(16'h0000);
        chk1(control_out, 1'b1);
        chk1(timing_active, 1'b0);
        step(run_edges(2));
        chk1(timing_active, 1'b0);
        chk1(control_out, 1'b1);
        s = 1'b0;
        step(1);
        chk1(control_out, 1'b0);
        fire(16'h0005);
        step(2);
        sv = 16'h0000;
        step(1);
        chk1(timing_active, 1'b0);
        chk1(time_up, 1'b0);
        fire(16'h0001);
        g = 1'b1;
        step(run_edges(3));
        chk16(elapsed, 16'h0000);
        chk1(timing_active, 1'b1);
        g = 1'b0;
        step(TK);
        chk1(timing_active, 1'b0);
        chk1(time_up, 1'b1);
        fire(16'h0005);
        step(6);
        resetn = 1'b0;
        s = 1'b0;
        step(1);
        chk1(timing_active, 1'b0);
        chk16(elapsed, 16'h0000);
        chk1(control_out, 1'b0);
        resetn = 1'b1;
        s = 1'b1;
        step(2);
        chk1(control_out, 1'b0);
        step(2);
        chk1(control_out, 1'b1);
        chk1(timing_active, 1'b1);
        r = 1'b1;
        s = 1'b0;
        step(1);
        chk1(timing_active, 1'b0);
        r = 1'b0;
        repeat (600) begin
            if (($urandom % 8) == 0) begin
                s = ~s;
                sv = 16'($urandom % 6);
            end
            g = (($urandom % 4) == 0);
            r = (($urandom % 32) == 0);
            model_edge(s, g, r, sv);
            step(1);
            chk1(control_out, m_out);
            chk1(timing_active, m_act);
            chk1(time_up, m_up);
            chk16(elapsed, m_cnt);
        end
        report_and_stop();
    end
endmodule
